// ==== rtc_irq_pkg.sv ====
// Shared constants and carriers for the calendar clock interrupt and entry check
// Assumes a 32-bit classic Wishbone slave with byte addressing
`default_nettype none

package rtc_irq_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SRC_N  = 5;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TOD      = 8'h00;
  localparam logic [7:0] OFS_DATE     = 8'h04;
  localparam logic [7:0] OFS_TALARM   = 8'h08;
  localparam logic [7:0] OFS_DALARM   = 8'h0c;
  localparam logic [7:0] OFS_FLAGS    = 8'h10;
  localparam logic [7:0] OFS_FLAG_CLR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ON   = 8'h18;
  localparam logic [7:0] OFS_IRQ_OFF  = 8'h1c;
  localparam logic [7:0] OFS_MASK     = 8'h20;
  localparam logic [7:0] OFS_VALID    = 8'h24;
  localparam logic [7:0] OFS_CTRL     = 8'h28;

  // ----------------------------------------------------------------
  // Source bit positions (status, clear, enable, disable, mask)
  // ----------------------------------------------------------------
  localparam int unsigned BIT_GRANT = 0;
  localparam int unsigned BIT_ALARM = 1;
  localparam int unsigned BIT_TICK  = 2;
  localparam int unsigned BIT_CLOCK = 3;
  localparam int unsigned BIT_DATE  = 4;

  // Validity bit positions, also entry register index
  localparam logic [1:0] ENT_TOD    = 2'h0;
  localparam logic [1:0] ENT_DATE   = 2'h1;
  localparam logic [1:0] ENT_TALARM = 2'h2;
  localparam logic [1:0] ENT_DALARM = 2'h3;

  // Control fields
  localparam int unsigned CTRL_CLK_SEL_LSB  = 0;
  localparam int unsigned CTRL_DATE_SEL_LSB = 2;
  localparam int unsigned CTRL_HOUR12_BIT   = 4;
  localparam int unsigned CTRL_W            = 5;

  // Reset values
  localparam logic [SRC_N-1:0]  MASK_RST  = 5'h00;
  localparam logic [SRC_N-1:0]  FLAGS_RST = 5'h00;
  localparam logic [3:0]        VALID_RST = 4'h0;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 5'h00;
  localparam logic [31:0]       ENTRY_RST = 32'h0000_0000;

  // BCD limits
  localparam logic [7:0] SEC_MAX   = 8'h59;
  localparam logic [7:0] HOUR24_MAX = 8'h23;
  localparam logic [7:0] HOUR12_MIN = 8'h01;
  localparam logic [7:0] HOUR12_MAX = 8'h12;
  localparam logic [7:0] CENT_MIN  = 8'h19;
  localparam logic [7:0] CENT_MAX  = 8'h20;
  localparam logic [7:0] YEAR_MAX  = 8'h99;
  localparam logic [7:0] MONTH_MIN = 8'h01;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] DAY_MIN   = 8'h01;
  localparam logic [7:0] DAY_MAX   = 8'h07;
  localparam logic [7:0] DATE_MIN  = 8'h01;
  localparam logic [7:0] DATE_MAX  = 8'h31;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic date_ev;
    logic clock_ev;
    logic tick;
    logic alarm;
    logic update_grant;
  } irq_src_t;

  typedef struct packed {
    logic [31:0] date_alarm;
    logic [31:0] time_alarm;
    logic [31:0] date;
    logic [31:0] time_of_day;
  } entries_t;

endpackage

`default_nettype wire

// ==== flag_bank.sv ====
// Sticky event flags: a set pulse latches, a clear pulse drops
// Assumes set and clear are one-cycle pulses in the clk_i domain
`default_nettype none

module flag_bank #(
  parameter int unsigned W = 5
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flags_o
);

  logic [W-1:0] flags_d;
  logic [W-1:0] flags_q;

  // ----------------------------------------------------------------
  // Per-bit next value
  // ----------------------------------------------------------------
  // Set beats clear so no event is lost on the clearing edge
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      flags_d[i] = set_i[i] | (flags_q[i] & ~clr_i[i]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_o = flags_q;

endmodule

`default_nettype wire

// ==== entry_check.sv ====
// Legality check of a value written to one of the four time entry registers
// Assumes BCD fields laid out as in the time, date and alarm registers
`default_nettype none

module entry_check (
  input  wire logic [1:0]  which_i,
  input  wire logic [31:0] value_i,
  input  wire logic        hour12_i,
  output logic             bad_o
);
  import rtc_irq_pkg::*;

  // Both digits decimal and value inside the window; BCD order is numeric order
  function automatic logic bcd_in(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    bcd_in = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction

  function automatic logic hour_ok(input logic [7:0] v, input logic ampm, input logic h12);
    if (h12) begin
      hour_ok = bcd_in(v, HOUR12_MIN, HOUR12_MAX);
    end else begin
      hour_ok = bcd_in(v, 8'h00, HOUR24_MAX) && !ampm;
    end
  endfunction

  logic ok;

  // ----------------------------------------------------------------
  // Field checks
  // ----------------------------------------------------------------
  always_comb begin
    ok = 1'b1;
    unique case (which_i)
      ENT_TOD, ENT_TALARM: begin
        ok = bcd_in({1'b0, value_i[6:0]}, 8'h00, SEC_MAX)
          && bcd_in({1'b0, value_i[14:8]}, 8'h00, SEC_MAX)
          && hour_ok({2'h0, value_i[21:16]}, value_i[22], hour12_i);
      end
      ENT_DATE: begin
        ok = bcd_in({1'b0, value_i[6:0]}, CENT_MIN, CENT_MAX)
          && bcd_in(value_i[15:8], 8'h00, YEAR_MAX)
          && bcd_in({3'h0, value_i[20:16]}, MONTH_MIN, MONTH_MAX)
          && bcd_in({5'h00, value_i[23:21]}, DAY_MIN, DAY_MAX)
          && bcd_in({2'h0, value_i[29:24]}, DATE_MIN, DATE_MAX);
      end
      ENT_DALARM: begin
        ok = bcd_in({3'h0, value_i[20:16]}, MONTH_MIN, MONTH_MAX)
          && bcd_in({2'h0, value_i[29:24]}, DATE_MIN, DATE_MAX);
      end
    endcase
    bad_o = !ok;
  end

endmodule

`default_nettype wire

// ==== rtc_irq_core.sv ====
// Interrupt mask, event flags and entry validity of the calendar clock
// Assumes a classic Wishbone master on clk_i and event pulses from the counters
`default_nettype none

// Functional notes
// - A one written to a disable port bit clears that source's mask bit and a zero leaves it alone.
// - Disable port bits 0 to 4 are update grant, alarm, tick, clock event and date event; others unused.
// - The disable port is write-only, reads nothing back, and touches only the five mask bits.
// - The mask view reads one for each enabled source and zero for each disabled one.
// - The mask view uses the disable port bit order and reads zero above bit 4.
// - The clock and date event masks follow whichever event the control selects.
// - Validity bit 0 flags a bad time of day and bit 1 a bad date.
// - Validity bit 2 flags a bad time alarm and bit 3 a bad date alarm.
// - Each validity flag is read-only, holds until its register is written, and a legal write clears it.
// - A one written to an enable port bit sets that mask bit, a zero does nothing, same bit order.
// - The event flags register holds the five sources in that order and each flag sticks until cleared.
// - A one written to a flag clear port bit clears that flag and a zero does nothing.
module rtc_irq_core (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              cyc_i,
  input  wire logic                              stb_i,
  input  wire logic                              we_i,
  input  wire logic [rtc_irq_pkg::ADDR_W-1:0]    adr_i,
  input  wire logic [3:0]                        sel_i,
  input  wire logic [rtc_irq_pkg::DATA_W-1:0]    dat_i,
  output logic      [rtc_irq_pkg::DATA_W-1:0]    dat_o,
  output logic                                   ack_o,
  input  wire rtc_irq_pkg::irq_src_t             raw_ev_i,
  input  wire logic [3:0]                        clock_ev_i,
  input  wire logic [2:0]                        date_ev_i,
  output var  rtc_irq_pkg::entries_t             entries_o,
  output logic      [3:0]                        entry_load_o,
  output logic                                   irq_o
);
  import rtc_irq_pkg::*;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // One wait state: ack rises the cycle after the request, drops after
  logic                ack_d;
  logic                ack_q;
  logic [DATA_W-1:0]   dat_d;
  logic [DATA_W-1:0]   dat_q;
  logic                req;
  logic                wr_now;
  logic [DATA_W-1:0]   byte_mask;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [SRC_N-1:0]    mask_d;
  logic [SRC_N-1:0]    mask_q;
  logic [3:0]          valid_d;
  logic [3:0]          valid_q;
  logic [CTRL_W-1:0]   ctrl_d;
  logic [CTRL_W-1:0]   ctrl_q;
  entries_t            ent_d;
  entries_t            ent_q;
  logic [3:0]          load_d;
  logic [3:0]          load_q;
  logic                irq_d;
  logic                irq_q;

  logic [SRC_N-1:0]    flag_set;
  logic [SRC_N-1:0]    flag_clr;
  logic [SRC_N-1:0]    flags;
  logic [1:0]          ent_idx;
  logic                ent_hit;
  logic [31:0]         ent_new;
  logic                ent_bad;
  logic                sel_clock_ev;
  logic                sel_date_ev;
  logic [1:0]          clock_sel;
  logic [1:0]          date_sel;

  // ----------------------------------------------------------------
  // Decode and pending
  // ----------------------------------------------------------------
  logic                cmd_wr;
  logic                hit_clr;
  logic                hit_on;
  logic                hit_off;
  logic                hit_ctrl;
  logic [SRC_N-1:0]    pend;

  assign req    = cyc_i & stb_i;
  assign wr_now = req & we_i & ack_q;

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign byte_mask[8*b +: 8] = {8{sel_i[b]}};
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Command and control bits all sit in byte lane 0, so only sel_i[0] counts
  always_comb begin
    cmd_wr   = wr_now & sel_i[0];
    hit_clr  = 1'b0;
    hit_on   = 1'b0;
    hit_off  = 1'b0;
    hit_ctrl = 1'b0;
    unique case (adr_i)
      OFS_FLAG_CLR: hit_clr  = cmd_wr;
      OFS_IRQ_ON:   hit_on   = cmd_wr;
      OFS_IRQ_OFF:  hit_off  = cmd_wr;
      OFS_CTRL:     hit_ctrl = cmd_wr;
      default:      hit_clr  = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Selected clock and date events
  // ----------------------------------------------------------------
  assign clock_sel = ctrl_q[CTRL_CLK_SEL_LSB +: 2];
  assign date_sel  = ctrl_q[CTRL_DATE_SEL_LSB +: 2];

  always_comb begin
    sel_clock_ev = clock_ev_i[clock_sel];
    sel_date_ev  = 1'b0;
    // Date select 3 picks no event at all
    if (date_sel <= 2'h2) begin
      sel_date_ev = date_ev_i[date_sel];
    end
  end

  // ----------------------------------------------------------------
  // Sticky event flags
  // ----------------------------------------------------------------
  always_comb begin
    flag_set            = raw_ev_i;
    flag_set[BIT_CLOCK] = sel_clock_ev;
    flag_set[BIT_DATE]  = sel_date_ev;
    // An event on the clearing edge still sets its flag
    flag_clr            = '0;
    if (hit_clr) begin
      flag_clr = dat_i[SRC_N-1:0];
    end
  end

  flag_bank #(
    .W (SRC_N)
  ) u_flags (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (flag_set),
    .clr_i   (flag_clr),
    .flags_o (flags)
  );

  // ----------------------------------------------------------------
  // Entry registers and validity
  // ----------------------------------------------------------------
  always_comb begin
    ent_hit = 1'b1;
    ent_idx = ENT_TOD;
    unique case (adr_i)
      OFS_TOD:    ent_idx = ENT_TOD;
      OFS_DATE:   ent_idx = ENT_DATE;
      OFS_TALARM: ent_idx = ENT_TALARM;
      OFS_DALARM: ent_idx = ENT_DALARM;
      default:    ent_hit = 1'b0;
    endcase
  end

  // Partial-lane writes are checked as merged, so a half-written entry may flag
  assign ent_new = (ent_q[32*ent_idx +: 32] & ~byte_mask) | (dat_i & byte_mask);

  entry_check u_check (
    .which_i  (ent_idx),
    .value_i  (ent_new),
    .hour12_i (ctrl_q[CTRL_HOUR12_BIT]),
    .bad_o    (ent_bad)
  );

  always_comb begin
    ent_d   = ent_q;
    valid_d = valid_q;
    load_d  = 4'h0;
    if (wr_now && ent_hit) begin
      // An illegal value is still stored; only its flag records it
      ent_d[32*ent_idx +: 32] = ent_new;
      load_d[ent_idx]         = 1'b1;
      // Only a write to the owning register changes its flag
      valid_d[ent_idx]        = ent_bad;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ent_q   <= {4{ENTRY_RST}};
      valid_q <= VALID_RST;
      load_q  <= 4'h0;
    end else begin
      ent_q   <= ent_d;
      valid_q <= valid_d;
      load_q  <= load_d;
    end
  end

  // ----------------------------------------------------------------
  // Mask and control
  // ----------------------------------------------------------------
  // Enable and disable are separate ports, so one write never does both
  for (genvar s = 0; s < SRC_N; s++) begin : g_mask
    always_comb begin
      mask_d[s] = mask_q[s];
      if (hit_on && dat_i[s]) begin
        mask_d[s] = 1'b1;
      end
      if (hit_off && dat_i[s]) begin
        mask_d[s] = 1'b0;
      end
    end
  end

  // A mode change does not recheck entries already stored
  always_comb begin
    ctrl_d = ctrl_q;
    if (hit_ctrl) begin
      ctrl_d = dat_i[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= MASK_RST;
      ctrl_q <= CTRL_RST;
    end else begin
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Pending sources; the request is registered so bus writes never glitch it
  for (genvar s = 0; s < SRC_N; s++) begin : g_pend
    assign pend[s] = flags[s] & mask_q[s];
  end

  always_comb begin
    irq_d = |pend;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data and acknowledge
  // ----------------------------------------------------------------
  // Write-only ports and unmapped offsets read zero
  always_comb begin
    // A held request is answered again only after ack drops
    ack_d = req & ~ack_q;
    dat_d = '0;
    if (req && !we_i && !ack_q) begin
      unique case (adr_i)
        OFS_TOD:    dat_d = ent_q.time_of_day;
        OFS_DATE:   dat_d = ent_q.date;
        OFS_TALARM: dat_d = ent_q.time_alarm;
        OFS_DALARM: dat_d = ent_q.date_alarm;
        OFS_FLAGS:  dat_d = {{(DATA_W-SRC_N){1'b0}}, flags};
        OFS_MASK:   dat_d = {{(DATA_W-SRC_N){1'b0}}, mask_q};
        OFS_VALID:  dat_d = {28'h0000000, valid_q};
        OFS_CTRL:   dat_d = {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
        default:    dat_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Load pulse lags the write by one edge, entries already new
  assign ack_o        = ack_q;
  assign dat_o        = dat_q;
  assign entries_o    = ent_q;
  assign entry_load_o = load_q;
  assign irq_o        = irq_q;

endmodule

`default_nettype wire

// ==== rtc_irq_core_props.sv ====
// Concurrent checks on mask, flags, interrupt and bus answer
// Assumes it is bound to rtc_irq_core and sees only its ports
`default_nettype none

module rtc_irq_core_props (
  input wire logic                           clk_i,
  input wire logic                           rst_i,
  input wire logic                           cyc_i,
  input wire logic                           stb_i,
  input wire logic                           we_i,
  input wire logic [rtc_irq_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0]                     sel_i,
  input wire logic [rtc_irq_pkg::DATA_W-1:0] dat_i,
  input wire logic [rtc_irq_pkg::DATA_W-1:0] dat_o,
  input wire logic                           ack_o,
  input wire rtc_irq_pkg::irq_src_t          raw_ev_i,
  input wire logic [3:0]                     clock_ev_i,
  input wire logic [2:0]                     date_ev_i,
  input wire logic [3:0]                     entry_load_o,
  input wire logic                           irq_o
);
  import rtc_irq_pkg::*;
  // ----------------------------------------------------------------
  // Shadow mask, updated only at the write's ack edge
  // ----------------------------------------------------------------
  logic [4:0] msk_q;
  logic [4:0] msk_d;
  logic       wr_ok;
  logic       ev_any;
  assign wr_ok  = ack_o && cyc_i && stb_i && we_i && sel_i[0];
  assign ev_any = (|raw_ev_i[2:0]) || (|clock_ev_i) || (|date_ev_i);
  always_comb begin
    msk_d = msk_q;
    if (wr_ok && adr_i == OFS_IRQ_ON) msk_d = msk_q | dat_i[4:0];
    if (wr_ok && adr_i == OFS_IRQ_OFF) msk_d = msk_q & ~dat_i[4:0];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) msk_q <= MASK_RST;
    else msk_q <= msk_d;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence tick_on_s;
    raw_ev_i.tick && msk_q[BIT_TICK] && !cyc_i;
  endsequence
  sequence clr_all_s;
    wr_ok && adr_i == OFS_FLAG_CLR && dat_i[4:0] == 5'h1f && !ev_any;
  endsequence
  a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_mask_read_val: assert property (ack_o && !we_i && adr_i == OFS_MASK |-> dat_o == {27'h0, msk_q})
    else $error("mask view wrong");
  a_off_reads_zero: assert property (ack_o && !we_i && adr_i == OFS_IRQ_OFF |-> dat_o == 32'h0)
    else $error("disable port readable");
  a_tick_irq_rise: assert property (tick_on_s |-> ##2 irq_o) else $error("no irq on tick");
  a_mask_off_quiet: assert property (msk_q == 5'h0 && $past(msk_q) == 5'h0 |-> !irq_o)
    else $error("irq while masked");
  a_irq_has_cause: assert property ($rose(irq_o) |-> $past(ev_any, 2) || $past(wr_ok && adr_i == OFS_IRQ_ON, 2))
    else $error("irq without cause");
  a_clr_drops_irq: assert property (clr_all_s |-> ##2 !irq_o) else $error("irq after clear");
  a_off_drops_irq: assert property (wr_ok && adr_i == OFS_IRQ_OFF && dat_i[4:0] == 5'h1f |-> ##2 !irq_o)
    else $error("irq after disable");
  a_tod_load_pulse: assert property (wr_ok && adr_i == OFS_TOD |=> entry_load_o[0])
    else $error("no load pulse");
  a_valid_upper_zero: assert property (ack_o && !we_i && adr_i == OFS_VALID |-> dat_o[31:4] == 28'h0)
    else $error("validity upper bits set");
endmodule

bind rtc_irq_core rtc_irq_core_props i_rtc_irq_core_props (.*);

`default_nettype wire

// ==== rtc_irq_core_test.sv ====
// Self-checking bench for rtc_irq_core over classic Wishbone
// Assumes the checker file is compiled alongside and binds itself
`default_nettype none

module rtc_irq_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_irq_pkg::*;
  // ----------------------------------------------------------------
  // Signals, tasks and sequence
  // ----------------------------------------------------------------
  localparam logic [31:0] BAD_V [4]  = '{32'h0000_0060, 32'h0121_2421, 32'h0000_6000, 32'h0113_0000};
  localparam logic [31:0] GOOD_V [4] = '{32'h0012_3456, 32'h0121_2420, 32'h0000_0000, 32'h0101_0000};
  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  irq_src_t    raw_ev_i;
  logic [3:0]  clock_ev_i;
  logic [2:0]  date_ev_i;
  entries_t    entries_o;
  logic [3:0]  entry_load_o;
  logic        irq_o;
  logic [31:0] rdat;
  logic [31:0] exp_v;
  int          n_errors;
  int          cmp_count;

  rtc_irq_core i_rtc_irq_core (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .cyc_i        (cyc_i),
    .stb_i        (stb_i),
    .we_i         (we_i),
    .adr_i        (adr_i),
    .sel_i        (sel_i),
    .dat_i        (dat_i),
    .dat_o        (dat_o),
    .ack_o        (ack_o),
    .raw_ev_i     (raw_ev_i),
    .clock_ev_i   (clock_ev_i),
    .date_ev_i    (date_ev_i),
    .entries_o    (entries_o),
    .entry_load_o (entry_load_o),
    .irq_o        (irq_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Values taken at the ack edge itself, before the slave updates
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, {31'h0, exp});
  endtask

  task automatic src_ev(input int i, input int cs, input int ds);
    @(posedge clk_i);
    if (i < 3) raw_ev_i[i] <= 1'b1;
    if (i == 3) clock_ev_i[cs] <= 1'b1;
    if (i == 4) date_ev_i[ds] <= 1'b1;
    @(posedge clk_i);
    raw_ev_i   <= '0;
    clock_ev_i <= 4'h0;
    date_ev_i  <= 3'h0;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    end_sim();
  end

  initial begin
    n_errors = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i} = 3'h0;
    adr_i = 8'h00;
    sel_i = 4'hf;
    dat_i = 32'h0;
    raw_ev_i = '0;
    clock_ev_i = 4'h0;
    date_ev_i = 3'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(OFS_MASK, 32'h0);
    rd_chk(OFS_FLAGS, 32'h0);
    rd_chk(OFS_VALID, 32'h0);
    bus(1'b1, OFS_IRQ_ON, 32'hffff_ffe0);
    rd_chk(OFS_MASK, 32'h0);
    exp_v = 32'h0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, OFS_IRQ_ON, 32'h1 << i);
      exp_v = exp_v | (32'h1 << i);
      rd_chk(OFS_MASK, exp_v);
    end
    bus(1'b1, OFS_IRQ_OFF, 32'hffff_ffe0);
    rd_chk(OFS_MASK, 32'h1f);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, OFS_IRQ_OFF, 32'h1 << i);
      exp_v = exp_v & ~(32'h1 << i);
      rd_chk(OFS_MASK, exp_v);
    end
    rd_chk(OFS_IRQ_OFF, 32'h0);
    for (int i = 0; i < 5; i++) begin
      src_ev(i, 0, 0);
      rd_chk(OFS_FLAGS, 32'h1 << i);
      irq_chk(1'b0);
      bus(1'b1, OFS_IRQ_ON, 32'h1 << i);
      irq_chk(1'b1);
      src_ev(i, 0, 0);
      bus(1'b1, OFS_FLAG_CLR, ~(32'h1 << i));
      rd_chk(OFS_FLAGS, 32'h1 << i);
      bus(1'b1, OFS_FLAG_CLR, 32'h1 << i);
      irq_chk(1'b0);
      bus(1'b1, OFS_IRQ_OFF, 32'h1 << i);
    end
    // Noon and month selected; the default events must now be ignored
    bus(1'b1, OFS_CTRL, 32'h6);
    bus(1'b1, OFS_IRQ_ON, 32'h18);
    src_ev(3, 0, 0);
    src_ev(4, 0, 0);
    rd_chk(OFS_FLAGS, 32'h0);
    irq_chk(1'b0);
    src_ev(3, 2, 1);
    src_ev(4, 2, 1);
    rd_chk(OFS_FLAGS, 32'h18);
    bus(1'b1, OFS_IRQ_OFF, 32'h8);
    irq_chk(1'b1);
    bus(1'b1, OFS_IRQ_OFF, 32'h1f);
    irq_chk(1'b0);
    bus(1'b1, OFS_FLAG_CLR, 32'h1f);
    rd_chk(OFS_FLAGS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'(4 * i), BAD_V[i]);
      rd_chk(OFS_VALID, (32'h1 << (i + 1)) - 32'h1);
    end
    bus(1'b1, OFS_VALID, 32'h0);
    rd_chk(OFS_VALID, 32'hf);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'(4 * i), GOOD_V[i]);
      rd_chk(OFS_VALID, (32'hf << (i + 1)) & 32'hf);
    end
    for (int i = 0; i < 4; i++) begin
      chk(entries_o[32*i +: 32], GOOD_V[i]);
      rd_chk(8'(4 * i), GOOD_V[i]);
    end
    // Midnight and year, then no date event, then 12-hour entries
    bus(1'b1, OFS_CTRL, 32'h1b);
    rd_chk(OFS_CTRL, 32'h1b);
    src_ev(3, 3, 2);
    src_ev(4, 3, 2);
    rd_chk(OFS_FLAGS, 32'h18);
    bus(1'b1, OFS_FLAG_CLR, 32'h1f);
    bus(1'b1, OFS_CTRL, 32'h1f);
    src_ev(4, 3, 2);
    rd_chk(OFS_FLAGS, 32'h0);
    bus(1'b1, OFS_TOD, 32'h0000_0000);
    rd_chk(OFS_VALID, 32'h1);
    bus(1'b1, OFS_TOD, 32'h0052_0000);
    rd_chk(OFS_VALID, 32'h0);
    bus(1'b1, 8'h30, 32'hffff_ffff);
    rd_chk(8'h30, 32'h0);
    // Reset in mid-run with a pending, enabled tick
    bus(1'b1, OFS_IRQ_ON, 32'h1f);
    src_ev(2, 0, 0);
    irq_chk(1'b1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(OFS_MASK, 32'h0);
    rd_chk(OFS_FLAGS, 32'h0);
    irq_chk(1'b0);
    end_sim();
  end
endmodule

`default_nettype wire
